// ==== shared/acfg_pkg.sv ====
// Constants, types and helpers for the converter serial configuration block.
// Assumes one register clock domain and one serial link clock domain.
package acfg_pkg;

    localparam int NSLOT = 12;
    localparam int SMP_W = 12;
    localparam int TEMP_W = 9;
    localparam int OVR_DELAY = 12;

    // Register offsets (7-bit address field)
    localparam logic [6:0] OFF_LINK_FILTER = 7'h00;
    localparam logic [6:0] OFF_CORR_FMT = 7'h01;
    localparam logic [6:0] OFF_OVR_THR = 7'h02;
    localparam logic [6:0] OFF_A_HOLD = 7'h03;
    localparam logic [6:0] OFF_SYNC_LOW = 7'h0E;
    localparam logic [6:0] OFF_SYNC_VREF = 7'h0F;
    localparam logic [6:0] OFF_B_HOLD = 7'h1A;
    localparam logic [6:0] OFF_TEMP = 7'h2B;
    localparam logic [6:0] OFF_SW_RESET = 7'h2C;
    localparam logic [6:0] OFF_SLEEP = 7'h37;
    localparam logic [6:0] OFF_BIAS = 7'h38;
    localparam logic [6:0] OFF_DRIVER = 7'h3A;
    localparam logic [6:0] OFF_A_PINS = 7'h66;
    localparam logic [6:0] OFF_B_PINS = 7'h67;

    // Storage slots of the writable registers
    localparam logic [3:0] SLOT_LINK_FILTER = 4'h0;
    localparam logic [3:0] SLOT_CORR_FMT = 4'h1;
    localparam logic [3:0] SLOT_OVR_THR = 4'h2;
    localparam logic [3:0] SLOT_A_HOLD = 4'h3;
    localparam logic [3:0] SLOT_SYNC_LOW = 4'h4;
    localparam logic [3:0] SLOT_SYNC_VREF = 4'h5;
    localparam logic [3:0] SLOT_B_HOLD = 4'h6;
    localparam logic [3:0] SLOT_SLEEP = 4'h7;
    localparam logic [3:0] SLOT_BIAS = 4'h8;
    localparam logic [3:0] SLOT_DRIVER = 4'h9;
    localparam logic [3:0] SLOT_A_PINS = 4'hA;
    localparam logic [3:0] SLOT_B_PINS = 4'hB;

    // Reset values
    localparam logic [15:0] DEF_LINK_FILTER = 16'h0000;
    localparam logic [15:0] DEF_CORR_FMT = 16'h0000;
    localparam logic [15:0] DEF_OVR_THR = 16'h0780;
    localparam logic [15:0] DEF_HOLD = 16'h4B18;
    localparam logic [15:0] DEF_SYNC_LOW = 16'hAAA8;
    localparam logic [15:0] DEF_SYNC_VREF = 16'hA000;
    localparam logic [15:0] DEF_SLEEP = 16'h0000;
    localparam logic [15:0] DEF_BIAS = 16'hFFFF;
    localparam logic [15:0] DEF_DRIVER = 16'h081B;
    localparam logic [15:0] DEF_PINS = 16'hFFFF;
    localparam logic [15:0] BIAS_RO_MASK = 16'h000F;
    localparam logic [15:0] SW_RESET_KEY = 16'hD2F0;

    typedef logic [NSLOT-1:0][15:0] acfg_bank_t;

    localparam acfg_bank_t REG_DEFAULTS = {DEF_PINS, DEF_PINS, DEF_DRIVER, DEF_BIAS,
        DEF_SLEEP, DEF_HOLD, DEF_SYNC_VREF, DEF_SYNC_LOW, DEF_HOLD, DEF_OVR_THR,
        DEF_CORR_FMT, DEF_LINK_FILTER};

    // Field positions
    localparam int FOUR_WIRE_BIT = 15;
    localparam int DECIM_BIT = 14;
    localparam int A_FILT_BIT = 12;
    localparam int B_FILT_BIT = 9;
    localparam int A_CORR_BIT = 15;
    localparam int B_CORR_BIT = 9;
    localparam int FMT_BIT = 3;
    localparam int PERF_BIT = 1;
    localparam int THR_LSB = 7;
    localparam int THR_MSB = 10;
    localparam int HOLD_BIT = 14;
    localparam int OVRA_EN_BIT = 1;
    localparam int OVRB_EN_BIT = 0;

    // Serial frame bit counts
    localparam logic [4:0] ADDR_LAST = 5'h07;
    localparam logic [4:0] DATA_FIRST = 5'h08;
    localparam logic [4:0] FRAME_LAST = 5'h17;
    localparam logic [4:0] FRAME_BITS = 5'h18;

    typedef struct packed {
        logic rd;
        logic [6:0] addr;
        logic [15:0] data;
    } acfg_xfer_t;

    typedef struct packed {
        logic decimation_enable;
        logic chan_a_filter_type;
        logic chan_b_filter_type;
        logic chan_a_autocal_enable;
        logic chan_b_autocal_enable;
        logic offset_binary;
        logic perf_mode_one;
        logic [3:0] overload_threshold;
        logic chan_a_autocal_hold;
        logic chan_b_autocal_hold;
        logic [15:0] sync_select_low;
        logic [15:0] sync_select_and_vref;
        logic [15:0] sleep_mode_select;
        logic [15:0] bias_and_power;
        logic [15:0] output_driver;
        logic [15:0] chan_a_pin_enable;
        logic [15:0] chan_b_pin_enable;
    } acfg_cfg_t;

    // Maps an address to {valid, slot}
    function automatic logic [4:0] acfg_slot(input logic [6:0] a);
        logic [4:0] r;
        r = 5'h00;
        unique case (a)
            OFF_LINK_FILTER: r = {1'b1, SLOT_LINK_FILTER};
            OFF_CORR_FMT: r = {1'b1, SLOT_CORR_FMT};
            OFF_OVR_THR: r = {1'b1, SLOT_OVR_THR};
            OFF_A_HOLD: r = {1'b1, SLOT_A_HOLD};
            OFF_SYNC_LOW: r = {1'b1, SLOT_SYNC_LOW};
            OFF_SYNC_VREF: r = {1'b1, SLOT_SYNC_VREF};
            OFF_B_HOLD: r = {1'b1, SLOT_B_HOLD};
            OFF_SLEEP: r = {1'b1, SLOT_SLEEP};
            OFF_BIAS: r = {1'b1, SLOT_BIAS};
            OFF_DRIVER: r = {1'b1, SLOT_DRIVER};
            OFF_A_PINS: r = {1'b1, SLOT_A_PINS};
            OFF_B_PINS: r = {1'b1, SLOT_B_PINS};
            default: r = 5'h00;
        endcase
        return r;
    endfunction : acfg_slot

    // Level at or above full scale times threshold over 16
    function automatic logic acfg_over(input logic [SMP_W-1:0] lvl, input logic [3:0] thr);
        return lvl >= {thr, 8'h00};
    endfunction : acfg_over

endpackage : acfg_pkg

// ==== rtl/acfg_sync3.sv ====
// Three-stage synchroniser for a single level.
// Assumes the input is stable for several destination clock cycles.
`timescale 1ns/1ps
module acfg_sync3 (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic d,
    output logic q
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic q;
    } acfg_sync_state_t;

    acfg_sync_state_t st;
    acfg_sync_state_t next_st;

    always_comb begin
        next_st = st;
        next_st.s1 = d;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        // Change taken only once two later stages agree
        if (st.s2 == st.s3) begin
            next_st.q = st.s3;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign q = st.q;

endmodule : acfg_sync3

// ==== rtl/acfg_delay.sv ====
// Fixed-length delay line for flag bits.
// Assumes the input comes from logic on the same clock.
`timescale 1ns/1ps
module acfg_delay #(
    parameter int DEPTH = 12,
    parameter int W = 2
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] pipe;
    } acfg_delay_state_t;

    acfg_delay_state_t st;
    acfg_delay_state_t next_st;

    always_comb begin
        next_st = st;
        next_st.pipe[0] = d;
        for (int i = 1; i < DEPTH; i++) begin
            next_st.pipe[i] = st.pipe[i-1];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign q = st.pipe[DEPTH-1];

endmodule : acfg_delay

// ==== rtl/acfg_serial_config.sv ====
// Serial configuration port and register bank of a dual-channel converter.
// Assumes a serial host on select/clock/data pins; registers on sys_clk.
//
// Behaviour
// - Frame is 8 address then 16 data bits
// - First rising edge captures read/write flag
// - Top address bit is read flag
// - Write data sampled on rising edges, stored
// - Read data shifted out MSB first
// - Read blocks writes until flag cleared
// - Register 0 bit 15 picks four-wire link
// - Register 0 bit 14 enables decimation
// - Filter type bits act only when decimating
// - Register 1 enables per-channel auto-correction
// - Register 1 bit 3 picks offset binary
// - Performance mode bit resets to zero
// - Four-bit shared over-range threshold, default 15
// - Over-range flag twelve cycles after overload
// - Hold bits clear or start correction loops
// - Hardware reset restores every register default
// - One write replaces the whole word of the one addressed register
// - Key written to reset register restores defaults
`timescale 1ns/1ps
module acfg_serial_config (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic serial_clk,
    input wire logic serial_select_n,
    input wire logic sdio_i,
    output logic sdio_o,
    output logic sdio_oe,
    output logic serial_out_pin_o,
    output logic serial_out_pin_oe,
    input wire logic [acfg_pkg::TEMP_W-1:0] temp_code,
    input wire logic [acfg_pkg::SMP_W-1:0] chan_a_level,
    input wire logic [acfg_pkg::SMP_W-1:0] chan_b_level,
    output logic overload_flag_a,
    output logic overload_flag_b,
    output acfg_pkg::acfg_cfg_t cfg
);

    // Link-side frame state, cleared while select is high
    typedef struct packed {
        logic [4:0] cnt;
        logic rw;
        logic [22:0] shift;
        logic [15:0] rdw;
    } acfg_frame_t;

    // Finished transfer handed to the register side
    typedef struct packed {
        logic tog;
        acfg_pkg::acfg_xfer_t xfer;
    } acfg_post_t;

    typedef struct packed {
        acfg_pkg::acfg_bank_t regs;
        logic lock;
        logic seen;
    } acfg_sys_t;

    acfg_frame_t frame;
    acfg_frame_t next_frame;
    acfg_post_t post;
    acfg_post_t next_post;
    logic [15:0] out_word;
    logic [15:0] next_out_word;
    acfg_sys_t sys;
    acfg_sys_t next_sys;

    logic tog_lvl;
    logic evt;
    logic [4:0] slot;
    logic four_wire;
    logic drive;
    logic trip_a;
    logic trip_b;
    logic [1:0] ovr_q;

    // Register read-back, including read-only and forced bits
    function automatic logic [15:0] acfg_read_word(input logic [6:0] a,
            input acfg_pkg::acfg_bank_t regs, input logic [acfg_pkg::TEMP_W-1:0] t);
        logic [4:0] sl;
        logic [15:0] r;
        sl = acfg_pkg::acfg_slot(a);
        r = 16'h0000;
        if (a == acfg_pkg::OFF_TEMP) begin
            r = {7'h00, t};
        end else if (a == acfg_pkg::OFF_BIAS) begin
            r = regs[acfg_pkg::SLOT_BIAS] | acfg_pkg::BIAS_RO_MASK;
        end else if (sl[4]) begin
            r = regs[sl[3:0]];
        end
        return r;
    endfunction : acfg_read_word

    // Link clock domain: bit counter and shifter
    always_comb begin
        next_frame = frame;
        if (frame.cnt != acfg_pkg::FRAME_BITS) begin
            next_frame.cnt = frame.cnt + 5'h01;
            next_frame.shift = {frame.shift[21:0], sdio_i};
        end
        if (frame.cnt == 5'h00) begin
            next_frame.rw = sdio_i;
        end
        if (frame.cnt == acfg_pkg::ADDR_LAST) begin
            // Bank words are quiet during a frame; writes land between frames
            next_frame.rdw = acfg_read_word({frame.shift[5:0], sdio_i}, sys.regs, temp_code);
        end
    end

    always_ff @(posedge serial_clk or posedge serial_select_n) begin
        if (serial_select_n) begin
            frame <= '0;
        end else begin
            frame <= next_frame;
        end
    end

    // Link clock domain: completed transfer, published by a toggle
    always_comb begin
        next_post = post;
        if (frame.cnt == acfg_pkg::ADDR_LAST && frame.rw) begin
            next_post.tog = ~post.tog;
            next_post.xfer.rd = 1'b1;
            next_post.xfer.addr = {frame.shift[5:0], sdio_i};
            next_post.xfer.data = 16'h0000;
        end else if (frame.cnt == acfg_pkg::FRAME_LAST && !frame.rw) begin
            next_post.tog = ~post.tog;
            next_post.xfer.rd = 1'b0;
            next_post.xfer.addr = frame.shift[21:15];
            next_post.xfer.data = {frame.shift[14:0], sdio_i};
        end
    end

    always_ff @(posedge serial_clk or negedge rst_b) begin
        if (!rst_b) begin
            post <= '0;
        end else begin
            post <= next_post;
        end
    end

    // Read data changes on falling edges so the host samples on rising ones
    always_comb begin
        next_out_word = out_word;
        if (frame.cnt == acfg_pkg::DATA_FIRST && frame.rw) begin
            next_out_word = frame.rdw;
        end else if (frame.cnt > acfg_pkg::DATA_FIRST) begin
            next_out_word = {out_word[14:0], 1'b0};
        end
    end

    always_ff @(negedge serial_clk or posedge serial_select_n) begin
        if (serial_select_n) begin
            out_word <= 16'h0000;
        end else begin
            out_word <= next_out_word;
        end
    end

    assign four_wire = sys.regs[acfg_pkg::SLOT_LINK_FILTER][acfg_pkg::FOUR_WIRE_BIT];
    assign drive = frame.rw && (frame.cnt >= acfg_pkg::DATA_FIRST) && !serial_select_n;
    assign sdio_o = out_word[15];
    assign serial_out_pin_o = out_word[15];
    assign sdio_oe = drive && !four_wire;
    assign serial_out_pin_oe = drive && four_wire;

    // Register clock domain
    acfg_sync3 u_tog_sync (
        .clk(sys_clk),
        .rst_b(rst_b),
        .d(post.tog),
        .q(tog_lvl)
    );

    assign evt = tog_lvl != sys.seen;
    assign slot = acfg_pkg::acfg_slot(post.xfer.addr);

    always_comb begin
        next_sys = sys;
        next_sys.seen = tog_lvl;
        if (evt) begin
            if (post.xfer.rd) begin
                next_sys.lock = 1'b1;
            end else if (sys.lock) begin
                next_sys.lock = 1'b0;
            end else if (post.xfer.addr == acfg_pkg::OFF_SW_RESET) begin
                if (post.xfer.data == acfg_pkg::SW_RESET_KEY) begin
                    next_sys.regs = acfg_pkg::REG_DEFAULTS;
                end
            end else if (slot[4]) begin
                next_sys.regs[slot[3:0]] = post.xfer.data;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sys.regs <= acfg_pkg::REG_DEFAULTS;
            sys.lock <= 1'b0;
            sys.seen <= 1'b0;
        end else begin
            sys <= next_sys;
        end
    end

    // Configuration outputs
    always_comb begin
        cfg.decimation_enable =
            sys.regs[acfg_pkg::SLOT_LINK_FILTER][acfg_pkg::DECIM_BIT];
        cfg.chan_a_filter_type = sys.regs[acfg_pkg::SLOT_LINK_FILTER][acfg_pkg::A_FILT_BIT]
            && cfg.decimation_enable;
        cfg.chan_b_filter_type = sys.regs[acfg_pkg::SLOT_LINK_FILTER][acfg_pkg::B_FILT_BIT]
            && cfg.decimation_enable;
        cfg.chan_a_autocal_enable =
            sys.regs[acfg_pkg::SLOT_CORR_FMT][acfg_pkg::A_CORR_BIT];
        cfg.chan_b_autocal_enable =
            sys.regs[acfg_pkg::SLOT_CORR_FMT][acfg_pkg::B_CORR_BIT];
        cfg.offset_binary = sys.regs[acfg_pkg::SLOT_CORR_FMT][acfg_pkg::FMT_BIT];
        cfg.perf_mode_one = sys.regs[acfg_pkg::SLOT_CORR_FMT][acfg_pkg::PERF_BIT];
        cfg.overload_threshold =
            sys.regs[acfg_pkg::SLOT_OVR_THR][acfg_pkg::THR_MSB:acfg_pkg::THR_LSB];
        cfg.chan_a_autocal_hold = sys.regs[acfg_pkg::SLOT_A_HOLD][acfg_pkg::HOLD_BIT];
        cfg.chan_b_autocal_hold = sys.regs[acfg_pkg::SLOT_B_HOLD][acfg_pkg::HOLD_BIT];
        cfg.sync_select_low = sys.regs[acfg_pkg::SLOT_SYNC_LOW];
        cfg.sync_select_and_vref = sys.regs[acfg_pkg::SLOT_SYNC_VREF];
        cfg.sleep_mode_select = sys.regs[acfg_pkg::SLOT_SLEEP];
        cfg.bias_and_power = sys.regs[acfg_pkg::SLOT_BIAS] | acfg_pkg::BIAS_RO_MASK;
        cfg.output_driver = sys.regs[acfg_pkg::SLOT_DRIVER];
        cfg.chan_a_pin_enable = sys.regs[acfg_pkg::SLOT_A_PINS];
        cfg.chan_b_pin_enable = sys.regs[acfg_pkg::SLOT_B_PINS];
    end

    // Over-range detection, gated by the flag output enables
    assign trip_a = sys.regs[acfg_pkg::SLOT_DRIVER][acfg_pkg::OVRA_EN_BIT]
        && acfg_pkg::acfg_over(chan_a_level, cfg.overload_threshold);
    assign trip_b = sys.regs[acfg_pkg::SLOT_DRIVER][acfg_pkg::OVRB_EN_BIT]
        && acfg_pkg::acfg_over(chan_b_level, cfg.overload_threshold);

    acfg_delay #(
        .DEPTH(acfg_pkg::OVR_DELAY),
        .W(2)
    ) u_ovr_delay (
        .clk(sys_clk),
        .rst_b(rst_b),
        .d({trip_a, trip_b}),
        .q(ovr_q)
    );

    assign overload_flag_a = ovr_q[1];
    assign overload_flag_b = ovr_q[0];

    // Checks
    dir_capture_a: assert property (@(posedge serial_clk) disable iff (serial_select_n)
        (frame.cnt == 5'h00) |=> (frame.rw == $past(sdio_i)))
        else $error("direction flag not taken from first bit");

    read_lock_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (evt && post.xfer.rd) |=> sys.lock)
        else $error("read did not set write lock");

    blocked_write_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (evt && !post.xfer.rd && sys.lock) |=> ($stable(sys.regs) && !sys.lock))
        else $error("locked write changed registers");

    write_store_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (evt && !post.xfer.rd && !sys.lock && post.xfer.addr == acfg_pkg::OFF_CORR_FMT)
        |=> (sys.regs[acfg_pkg::SLOT_CORR_FMT] == $past(post.xfer.data)))
        else $error("write data not stored");

    soft_reset_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (evt && !post.xfer.rd && !sys.lock && post.xfer.addr == acfg_pkg::OFF_SW_RESET
        && post.xfer.data == acfg_pkg::SW_RESET_KEY) |=> (sys.regs == acfg_pkg::REG_DEFAULTS))
        else $error("key write did not restore defaults");

    filter_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (cfg.chan_a_filter_type || cfg.chan_b_filter_type) |-> cfg.decimation_enable)
        else $error("filter type active without decimation");

    ovr_latency_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        trip_a |-> ##12 overload_flag_a)
        else $error("over-range flag not twelve cycles later");

    idle_release_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        serial_select_n |-> (!sdio_oe && !serial_out_pin_oe))
        else $error("output driven while deselected");

    pin_choice_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !(sdio_oe && serial_out_pin_oe) && (!serial_out_pin_oe || four_wire))
        else $error("read data on wrong pin");

    sdio_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        four_wire |-> !sdio_oe)
        else $error("data pin driven in four-wire mode");

    read_drive_a: assert property (@(posedge serial_clk) disable iff (serial_select_n)
        (frame.rw && frame.cnt >= acfg_pkg::DATA_FIRST) |-> (sdio_oe || serial_out_pin_oe))
        else $error("read data not driven");

    count_bound_a: assert property (@(posedge serial_clk) disable iff (serial_select_n)
        frame.cnt <= acfg_pkg::FRAME_BITS)
        else $error("frame bit count overran");

    write_post_a: assert property (@(posedge serial_clk)
        disable iff (serial_select_n || !rst_b)
        (frame.cnt == acfg_pkg::FRAME_LAST && !frame.rw) |-> (next_post.tog != post.tog))
        else $error("finished write not published");

    read_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (evt && post.xfer.rd) |=> $stable(sys.regs))
        else $error("read changed registers");

    ignore_write_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (evt && !post.xfer.rd && !sys.lock && !slot[4]
        && post.xfer.addr != acfg_pkg::OFF_SW_RESET) |=> $stable(sys.regs))
        else $error("unmapped write changed registers");

    ovr_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !trip_a |-> ##12 !overload_flag_a)
        else $error("over-range flag without overload");

    ovr_b_latency_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        trip_b |-> ##12 overload_flag_b)
        else $error("channel b flag not twelve cycles later");

endmodule : acfg_serial_config

// ==== tb/acfg_host_model.sv ====
// Serial host model: drives select, link clock and data, samples read-back bits.
// Assumes the bench resolves the shared data line from both parties' enables.
`timescale 1ns/1ps
module acfg_host_model (
    output logic serial_clk,
    output logic serial_select_n,
    output logic host_sdio,
    output logic host_en,
    input wire logic sdio_line,
    input wire logic sdo_line
);
    logic four_wire;

    initial begin
        serial_clk = 1'b0;
        serial_select_n = 1'b0;
        host_sdio = 1'b0;
        host_en = 1'b0;
        four_wire = 1'b0;
        // Clean rising select edge clears the frame state
        #1 serial_select_n = 1'b1;
    end

    // Clock stands still low outside frames; nbits below 24 cuts the frame short
    task automatic frame(input logic rd, input logic [6:0] addr, input logic [15:0] wdata,
            input int nbits, output logic [15:0] rdata);
        logic [23:0] word;
        word = {rd, addr, wdata};
        rdata = 16'h0000;
        serial_select_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            host_en = !(rd && i >= 8);
            host_sdio = host_en ? word[23 - i] : ~host_sdio;
            #80 serial_clk = 1'b1;
            if (i >= 8) begin
                rdata = {rdata[14:0], four_wire ? sdo_line : sdio_line};
            end
            #80 serial_clk = 1'b0;
        end
        #40 serial_select_n = 1'b1;
        host_en = 1'b0;
        #700;
    endtask : frame
endmodule : acfg_host_model

// ==== tb/testbench.sv ====
// Self-checking bench for the serial configuration block.
// Assumes the host model above and a 10 MHz register clock.
`timescale 1ns/1ps
module testbench;
    logic sys_clk, rst_b, sdio_o, sdio_oe, sdo_o, sdo_oe, ovf_a, ovf_b, junk;
    logic serial_clk, serial_select_n, host_sdio, host_en, sdio_line, sdo_line;
    logic [acfg_pkg::TEMP_W-1:0] temp_code;
    logic [acfg_pkg::SMP_W-1:0] lvl_a, lvl_b;
    acfg_pkg::acfg_cfg_t cfg;
    int bad_count, n_checks;
    logic [15:0] rv, xv;
    logic [6:0] da [14] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h0E, 7'h0F, 7'h1A, 7'h37,
        7'h38, 7'h3A, 7'h66, 7'h67, 7'h2C, 7'h7F};
    logic [15:0] dv [14] = '{16'h0000, 16'h0000, 16'h0780, 16'h4B18, 16'hAAA8, 16'hA000,
        16'h4B18, 16'h0000, 16'hFFFF, 16'h081B, 16'hFFFF, 16'hFFFF, 16'h0000, 16'h0000};

    // Released lines show a toggling pattern
    assign sdio_line = sdio_oe ? sdio_o : (host_en ? host_sdio : junk);
    assign sdo_line = sdo_oe ? sdo_o : junk;

    acfg_host_model host (.serial_clk(serial_clk), .serial_select_n(serial_select_n),
        .host_sdio(host_sdio), .host_en(host_en), .sdio_line(sdio_line), .sdo_line(sdo_line));

    acfg_serial_config dut (.sys_clk(sys_clk), .rst_b(rst_b), .serial_clk(serial_clk),
        .serial_select_n(serial_select_n), .sdio_i(sdio_line), .sdio_o(sdio_o),
        .sdio_oe(sdio_oe), .serial_out_pin_o(sdo_o), .serial_out_pin_oe(sdo_oe),
        .temp_code(temp_code), .chan_a_level(lvl_a), .chan_b_level(lvl_b),
        .overload_flag_a(ovf_a), .overload_flag_b(ovf_b), .cfg(cfg));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    always @(negedge sys_clk) junk <= ~junk;

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic rd(input logic [6:0] a, output logic [15:0] d);
        host.frame(1'b1, a, 16'h0000, 24, d);
    endtask : rd

    // Leading frame to an unmapped place clears any read lock
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        logic [15:0] x;
        host.frame(1'b0, 7'h7F, 16'h0000, 24, x);
        host.frame(1'b0, a, d, 24, x);
    endtask : wr

    task automatic rc(input string what, input logic [6:0] a, input logic [15:0] exp);
        rd(a, rv);
        check(what, rv, exp);
    endtask : rc

    task automatic hw_reset;
        @(negedge sys_clk);
        rst_b = 1'b0;
        repeat (8) @(negedge sys_clk);
        rst_b = 1'b1;
        repeat (20) @(negedge sys_clk);
    endtask : hw_reset

    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results

    initial begin
        #1000000;
        bad_count++;
        results();
    end

    initial begin
        rst_b = 1'b1;
        junk = 1'b0;
        bad_count = 0;
        n_checks = 0;
        temp_code = 9'h1A5;
        lvl_a = 12'h000;
        lvl_b = 12'h000;
        hw_reset();
        for (int i = 0; i < 14; i++) begin
            rc("default", da[i], dv[i]);
        end
        rc("temp", 7'h2B, 16'h01A5);
        check("oe idle", 16'(sdio_oe), 16'h0000);
        $display("test defaults done");

        rd(7'h00, rv);
        host.frame(1'b0, 7'h02, 16'h0400, 24, xv);
        host.frame(1'b0, 7'h01, 16'h820A, 24, xv);
        rc("locked write", 7'h02, 16'h0780);
        rc("write after lock", 7'h01, 16'h820A);
        check("a corr", 16'(cfg.chan_a_autocal_enable), 16'h0001);
        check("b corr", 16'(cfg.chan_b_autocal_enable), 16'h0001);
        check("format", 16'(cfg.offset_binary), 16'h0001);
        check("perf", 16'(cfg.perf_mode_one), 16'h0001);
        $display("test lock done");

        wr(7'h00, 16'h1200);
        check("a filt off", 16'(cfg.chan_a_filter_type), 16'h0000);
        check("decim off", 16'(cfg.decimation_enable), 16'h0000);
        wr(7'h00, 16'h5200);
        check("a filt", 16'(cfg.chan_a_filter_type), 16'h0001);
        check("b filt", 16'(cfg.chan_b_filter_type), 16'h0001);
        check("decim", 16'(cfg.decimation_enable), 16'h0001);
        wr(7'h03, 16'h4B18);
        wr(7'h1A, 16'h4B18);
        wr(7'h03, 16'h0B18);
        check("a hold", 16'(cfg.chan_a_autocal_hold), 16'h0000);
        check("b hold", 16'(cfg.chan_b_autocal_hold), 16'h0001);
        wr(7'h2B, 16'hFFFF);
        rc("temp ro", 7'h2B, 16'h01A5);
        $display("test fields done");

        wr(7'h02, 16'h0200);
        wr(7'h3A, 16'h081A);
        check("thr", 16'(cfg.overload_threshold), 16'h0004);
        @(negedge sys_clk);
        lvl_a = 12'h3FF;
        lvl_b = 12'hFFF;
        repeat (20) @(negedge sys_clk);
        check("below thr", 16'(ovf_a), 16'h0000);
        lvl_a = 12'h400;
        repeat (11) @(posedge sys_clk);
        #1;
        check("ovr early", 16'(ovf_a), 16'h0000);
        repeat (2) @(posedge sys_clk);
        #1;
        check("ovr late", 16'(ovf_a), 16'h0001);
        check("ovr b off", 16'(ovf_b), 16'h0000);
        $display("test overload done");

        wr(7'h00, 16'h8000);
        host.four_wire = 1'b1;
        rc("four wire", 7'h02, 16'h0200);
        wr(7'h00, 16'h0000);
        host.four_wire = 1'b0;
        rc("three wire", 7'h00, 16'h0000);
        $display("test link mode done");

        host.frame(1'b0, 7'h7F, 16'h0000, 24, xv);
        host.frame(1'b0, 7'h02, 16'hFFFF, 12, xv);
        rc("short frame", 7'h02, 16'h0200);
        wr(7'h2C, 16'h1234);
        rc("bad key", 7'h01, 16'h820A);
        wr(7'h2C, 16'hD2F0);
        rc("key 01", 7'h01, 16'h0000);
        rc("key 02", 7'h02, 16'h0780);
        rc("key 2C", 7'h2C, 16'h0000);
        wr(7'h01, 16'h8200);
        hw_reset();
        rc("hw reset", 7'h01, 16'h0000);
        $display("test resets done");
        results();
    end
endmodule : testbench
